// File: hw/tiltq_atan_core.sv
// Iterative vectoring arctangent: angle of |axis| against |vert| in degrees.
// Assumes start is only pulsed while the previous answer has been given.
`timescale 1ns/1ps
module tiltq_atan_core
	import tiltq_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	tiltq_atan_if.core   port
);

	logic                     run_q, run_d;
	logic [3:0]               iter_q, iter_d;
	logic signed [ACC_W-1:0]  x_q, x_d, y_q, y_d;
	logic signed [15:0]       acc_q, acc_d;
	logic [6:0]               angle_q, angle_d;
	logic                     done_q, done_d;
	logic signed [15:0]       rnd;

	function automatic logic signed [ACC_W-1:0] mag(input logic signed [15:0] v);
		logic signed [ACC_W-1:0] w;
		w = {{(ACC_W-16){v[15]}}, v};
		mag = v[15] ? -w : w;
	endfunction : mag

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		run_d   = run_q;
		iter_d  = iter_q;
		x_d     = x_q;
		y_d     = y_q;
		acc_d   = acc_q;
		angle_d = angle_q;
		done_d  = 1'b0;
		rnd     = 16'sh0000;
		if (!run_q) begin
			if (port.start) begin
				x_d    = mag(port.vert);
				y_d    = mag(port.axis);
				acc_d  = 16'sh0000;
				iter_d = 4'h0;
				run_d  = 1'b1;
			end
		end else begin
			// Rotation gain cancels out: only the accumulated angle is used
			if (y_q >= 0) begin
				x_d   = x_q + (y_q >>> iter_q);
				y_d   = y_q - (x_q >>> iter_q);
				acc_d = acc_q + atan_step(iter_q);
			end else begin
				x_d   = x_q - (y_q >>> iter_q);
				y_d   = y_q + (x_q >>> iter_q);
				acc_d = acc_q - atan_step(iter_q);
			end
			if (iter_q == ATAN_LAST) begin
				run_d  = 1'b0;
				done_d = 1'b1;
				rnd    = acc_d + ATAN_HALF;
				// Twelve steps leave well under a tenth of a degree before rounding
				if (rnd < 0)
					angle_d = 7'h00;
				else if (rnd[14:8] > ANGLE_MAX)
					angle_d = ANGLE_MAX;
				else
					angle_d = rnd[14:8];
			end else begin
				iter_d = iter_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q   <= 1'b0;
			iter_q  <= 4'h0;
			x_q     <= '0;
			y_q     <= '0;
			acc_q   <= 16'sh0000;
			angle_q <= 7'h00;
			done_q  <= 1'b0;
		end else begin
			run_q   <= run_d;
			iter_q  <= iter_d;
			x_q     <= x_d;
			y_q     <= y_d;
			acc_q   <= acc_d;
			angle_q <= angle_d;
			done_q  <= done_d;
		end
	end

	assign port.done  = done_q;
	assign port.angle = angle_q;

	AST_CORE_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
		(port.start && !run_q) |=> !port.done [*8] ##1 !port.done [*4] ##1 port.done)
		else $error("arctangent answer not 13 cycles after start");
	AST_CORE_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		port.done |-> (port.angle <= ANGLE_MAX))
		else $error("arctangent answer above 90 degrees");

endmodule : tiltq_atan_core

// File: hw/tiltq_status_top.sv
// Tilt status block: filters three-axis samples, derives X/Z and Y/Z angles
// and quadrants, flags jumps, and exposes status and config registers.
// Assumes one sample per execution, strobed with smp_valid while smp_ready.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module tiltq_status_top
	import tiltq_pkg::*;
(
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic signed [tiltq_pkg::SAMPLE_W-1:0] smp_x,
	input  wire logic signed [tiltq_pkg::SAMPLE_W-1:0] smp_y,
	input  wire logic signed [tiltq_pkg::SAMPLE_W-1:0] smp_z,
	input  wire logic                                 smp_valid,
	output wire logic                                 smp_ready,
	input  wire logic [3:0]                           reg_addr,
	input  wire logic [7:0]                           reg_wdata,
	input  wire logic                                 reg_wr,
	input  wire logic                                 reg_rd,
	output wire logic [7:0]                           reg_rdata,
	output wire logic                                 irq
);

	tiltq_state_t                 state_q, state_d;
	logic signed [SAMPLE_W-1:0]   filt_x_q, filt_x_d, filt_y_q, filt_y_d, filt_z_q, filt_z_d;
	logic [7:0]                   xz_stat_q, xz_stat_d, yz_stat_q, yz_stat_d;
	logic [7:0]                   quad_stat_q, quad_stat_d;
	logic [2:0]                   lp_coef_q, lp_coef_d;
	logic [6:0]                   cfg_q, cfg_d;
	logic [IRQ_W-1:0]             irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, events;
	logic [7:0]                   rdata_q, rdata_d;
	logic                         xz_jump, yz_jump, quad_chg, update;
	logic [1:0]                   xz_plane_quadrant, yz_plane_quadrant;
	logic                         xz_on, yz_on;
	logic [3:0]                   thresh;

	tiltq_atan_if xz_if ();
	tiltq_atan_if yz_if ();

	tiltq_atan_core u_xz_core (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (xz_if.core)
	);

	tiltq_atan_core u_yz_core (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (yz_if.core)
	);

	// First-order filter: cur += (smp - cur) >> k
	function automatic logic signed [SAMPLE_W-1:0] lp_step(
		input logic signed [SAMPLE_W-1:0] cur,
		input logic signed [SAMPLE_W-1:0] smp,
		input logic [2:0]                 k);
		logic signed [SAMPLE_W:0] diff;
		logic signed [SAMPLE_W:0] sum;
		diff = {smp[SAMPLE_W-1], smp} - {cur[SAMPLE_W-1], cur};
		// Both terms signed, or the shift would fill with zeros
		sum  = $signed({cur[SAMPLE_W-1], cur}) + (diff >>> k);
		lp_step = sum[SAMPLE_W-1:0];
	endfunction : lp_step

	assign xz_on  = cfg_q[XZ_EN_BIT];
	assign yz_on  = cfg_q[YZ_EN_BIT];
	assign thresh = cfg_q[3:0];

	////////////////////////////////////////////////////////////////////////////
	// Execution sequence, filter and status
	assign smp_ready   = (state_q == ST_IDLE);
	assign update      = (state_q == ST_WAIT) && xz_if.done;
	assign xz_if.start = (state_q == ST_START) && xz_on;
	assign yz_if.start = (state_q == ST_START) && yz_on;
	assign xz_if.axis  = filt_x_q;
	assign xz_if.vert  = filt_z_q;
	assign yz_if.axis  = filt_y_q;
	assign yz_if.vert  = filt_z_q;

	always_comb begin
		state_d     = state_q;
		filt_x_d    = filt_x_q;
		filt_y_d    = filt_y_q;
		filt_z_d    = filt_z_q;
		xz_stat_d   = xz_stat_q;
		yz_stat_d   = yz_stat_q;
		quad_stat_d = quad_stat_q;
		xz_plane_quadrant     = quad_code(filt_x_q, filt_z_q);
		yz_plane_quadrant     = quad_code(filt_y_q, filt_z_q);
		xz_jump     = abs_diff(xz_if.angle, xz_stat_q[6:0]) > {3'h0, thresh};
		yz_jump     = abs_diff(yz_if.angle, yz_stat_q[6:0]) > {3'h0, thresh};
		quad_chg    = (xz_on && xz_plane_quadrant != quad_stat_q[XZQ_LSB +: 2]) ||
		              (yz_on && yz_plane_quadrant != quad_stat_q[YZQ_LSB +: 2]);
		case (state_q)
			ST_IDLE: begin
				if (smp_valid) begin
					filt_x_d = lp_step(filt_x_q, smp_x, lp_coef_q);
					filt_y_d = lp_step(filt_y_q, smp_y, lp_coef_q);
					filt_z_d = lp_step(filt_z_q, smp_z, lp_coef_q);
					state_d  = ST_START;
				end
			end
			ST_START: begin
				// Both planes off: nothing to sense, status is left alone
				state_d = (xz_on || yz_on) ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT: begin
				// Cores run in lockstep, so the X/Z done stands for both
				if (!xz_on && yz_if.done) begin
					state_d   = ST_IDLE;
					yz_stat_d = {yz_jump, yz_if.angle};
					quad_stat_d = {quad_chg, 1'b0, quad_stat_q[XZQ_LSB +: 2], yz_plane_quadrant, 2'h0};
				end else if (update) begin
					state_d = ST_IDLE;
					// Old status fields serve as the previous values
					xz_stat_d = {xz_jump, xz_if.angle};
					if (yz_on)
						yz_stat_d = {yz_jump, yz_if.angle};
					quad_stat_d = {quad_chg, 1'b0, xz_plane_quadrant,
						yz_on ? yz_plane_quadrant : quad_stat_q[YZQ_LSB +: 2], 2'h0};
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			filt_x_q    <= '0;
			filt_y_q    <= '0;
			filt_z_q    <= '0;
			xz_stat_q   <= STATUS_RESET;
			yz_stat_q   <= STATUS_RESET;
			quad_stat_q <= STATUS_RESET;
		end else begin
			state_q     <= state_d;
			filt_x_q    <= filt_x_d;
			filt_y_q    <= filt_y_d;
			filt_z_q    <= filt_z_d;
			xz_stat_q   <= xz_stat_d;
			yz_stat_q   <= yz_stat_d;
			quad_stat_q <= quad_stat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port and interrupt
	always_comb begin
		events = '0;
		if (state_q == ST_WAIT && state_d == ST_IDLE) begin
			events[IRQ_XZ_BIT] = xz_stat_d[FLAG_BIT] && xz_on;
			events[IRQ_YZ_BIT] = yz_stat_d[FLAG_BIT] && yz_on;
			events[IRQ_Q_BIT]  = quad_stat_d[FLAG_BIT];
		end
		lp_coef_d  = lp_coef_q;
		cfg_d      = cfg_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (reg_wr) begin
			case (reg_addr)
				OFS_LP_COEF:    lp_coef_d  = reg_wdata[2:0];
				OFS_TILT_CFG:   cfg_d      = reg_wdata[6:0];
				OFS_IRQ_STATUS: irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_W-1:0];
				OFS_IRQ_MASK:   irq_mask_d = reg_wdata[IRQ_W-1:0];
				default:        ;
			endcase
		end
		// A new event wins over a clear in the same cycle
		irq_stat_d = irq_stat_d | events;
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				OFS_XZ_STATUS:   rdata_d = xz_stat_q;
				OFS_YZ_STATUS:   rdata_d = yz_stat_q;
				OFS_XY_STATUS:   rdata_d = 8'h00;
				OFS_QUAD_STATUS: rdata_d = quad_stat_q;
				OFS_LP_COEF:     rdata_d = {5'h00, lp_coef_q};
				OFS_TILT_CFG:    rdata_d = {1'b0, cfg_q};
				OFS_IRQ_STATUS:  rdata_d = {5'h00, irq_stat_q};
				OFS_IRQ_MASK:    rdata_d = {5'h00, irq_mask_q};
				default:         rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_coef_q  <= LP_COEF_RESET;
			cfg_q      <= TILT_CFG_RESET;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			rdata_q    <= 8'h00;
		end else begin
			lp_coef_q  <= lp_coef_d;
			cfg_q      <= cfg_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			rdata_q    <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_XZ_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(update && xz_on) |=> xz_stat_q[FLAG_BIT] ==
			(abs_diff(xz_stat_q[6:0], $past(xz_stat_q[6:0])) > {3'h0, $past(thresh)}))
		else $error("X/Z jump flag does not match angle change");
	AST_YZ_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(update && yz_on) |=> yz_stat_q[FLAG_BIT] ==
			(abs_diff(yz_stat_q[6:0], $past(yz_stat_q[6:0])) > {3'h0, $past(thresh)}))
		else $error("Y/Z jump flag does not match angle change");
	AST_ANGLE_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
		(xz_stat_q[6:0] <= ANGLE_MAX) && (yz_stat_q[6:0] <= ANGLE_MAX))
		else $error("status angle above 90 degrees");
	AST_XY_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == OFS_XY_STATUS) |=> reg_rdata == 8'h00)
		else $error("X/Y status byte not zero");
	AST_QUAD_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
		(update && xz_on) |=> (quad_stat_q[XZQ_LSB +: 2] ==
			quad_code($past(filt_x_q), $past(filt_z_q))) && (quad_stat_q[1:0] == 2'h0))
		else $error("X/Z quadrant code wrong or X/Y field set");
	AST_QUAD_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(update && xz_on && yz_on) |=> quad_stat_q[FLAG_BIT] ==
			(quad_stat_q[5:2] != $past(quad_stat_q[5:2])))
		else $error("quadrant change flag wrong");
	AST_STATUS_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q != ST_WAIT) |=> $stable(xz_stat_q) && $stable(yz_stat_q) &&
			$stable(quad_stat_q))
		else $error("status changed outside an execution");
	AST_DISABLED_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		!xz_on |=> $stable(xz_stat_q))
		else $error("disabled X/Z plane status changed");
	AST_THRESH_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		!(reg_wr && reg_addr == OFS_TILT_CFG) |=> $stable(thresh))
		else $error("threshold changed without a write");
	AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
		(irq_stat_q[IRQ_Q_BIT] && !(reg_wr && reg_addr == OFS_IRQ_STATUS))
			|=> irq_stat_q[IRQ_Q_BIT])
		else $error("sticky quadrant event lost");

endmodule : tiltq_status_top

// File: pkg/tiltq_atan_if.sv
// Request and answer between the status logic and one arctangent core.
// Assumes both ends share clk; start and done are one-cycle pulses.
`timescale 1ns/1ps
interface tiltq_atan_if;
	logic                 start;
	logic signed [15:0]   axis;
	logic signed [15:0]   vert;
	logic                 done;
	logic [6:0]           angle;

	modport core (input start, input axis, input vert, output done, output angle);
	modport user (output start, output axis, output vert, input done, input angle);
endinterface : tiltq_atan_if

// File: pkg/tiltq_pkg.sv
// Constants, register map and shared helpers of the tilt status block.
// Assumes a single 50 MHz clock domain and byte-wide registers.
package tiltq_pkg;

	localparam int SAMPLE_W = 16;
	localparam int ACC_W    = 20;
	localparam int CLK_MHZ  = 50;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [3:0] OFS_XZ_STATUS   = 4'h0;
	localparam logic [3:0] OFS_YZ_STATUS   = 4'h1;
	localparam logic [3:0] OFS_XY_STATUS   = 4'h2;
	localparam logic [3:0] OFS_QUAD_STATUS = 4'h3;
	localparam logic [3:0] OFS_LP_COEF     = 4'h4;
	localparam logic [3:0] OFS_TILT_CFG    = 4'h5;
	localparam logic [3:0] OFS_IRQ_STATUS  = 4'h6;
	localparam logic [3:0] OFS_IRQ_MASK    = 4'h7;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FLAG_BIT   = 7;
	localparam int XZQ_LSB    = 4;
	localparam int YZQ_LSB    = 2;
	localparam int XY_EN_BIT  = 6;
	localparam int YZ_EN_BIT  = 5;
	localparam int XZ_EN_BIT  = 4;
	localparam int IRQ_XZ_BIT = 0;
	localparam int IRQ_YZ_BIT = 1;
	localparam int IRQ_Q_BIT  = 2;
	localparam int IRQ_W      = 3;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset, and the largest angle
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [2:0] LP_COEF_RESET  = 3'h5;
	localparam logic [6:0] TILT_CFG_RESET = 7'h79;
	localparam logic [6:0] ANGLE_MAX      = 7'h5a;

	////////////////////////////////////////////////////////////////////////////
	// Arctangent core: angle accumulator is degrees with 8 fraction bits
	localparam logic [3:0]        ATAN_LAST = 4'hb;
	localparam logic signed [15:0] ATAN_HALF = 16'sh0080;

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} tiltq_state_t;

	function automatic logic signed [15:0] atan_step(input logic [3:0] i);
		case (i)
			4'h0: atan_step = 16'sh2d00;
			4'h1: atan_step = 16'sh1a91;
			4'h2: atan_step = 16'sh0e09;
			4'h3: atan_step = 16'sh0720;
			4'h4: atan_step = 16'sh0394;
			4'h5: atan_step = 16'sh01ca;
			4'h6: atan_step = 16'sh00e5;
			4'h7: atan_step = 16'sh0073;
			4'h8: atan_step = 16'sh0039;
			4'h9: atan_step = 16'sh001d;
			4'ha: atan_step = 16'sh000e;
			4'hb: atan_step = 16'sh0007;
			default: atan_step = 16'sh0000;
		endcase
	endfunction : atan_step

	// Zero counts as positive on either axis
	function automatic logic [1:0] quad_code(input logic signed [SAMPLE_W-1:0] axis,
		input logic signed [SAMPLE_W-1:0] vert);
		case ({axis[SAMPLE_W-1], vert[SAMPLE_W-1]})
			2'b00:   quad_code = 2'h0;
			2'b01:   quad_code = 2'h1;
			2'b11:   quad_code = 2'h2;
			default: quad_code = 2'h3;
		endcase
	endfunction : quad_code

	function automatic logic [6:0] abs_diff(input logic [6:0] a, input logic [6:0] b);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction : abs_diff

endpackage : tiltq_pkg

// File: test/tilt_angle_quadrant_status_tb.sv
// Self-checking bench of the tilt status block with a sample front end model.
// Assumes read data one cycle after the read strobe; angles within one degree.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tilt_angle_quadrant_status_tb;
	import tiltq_pkg::*;
	typedef struct {logic [7:0] exp; logic [7:0] care; bit ang;} tiltq_note_t;
	logic                         clk, rst_n, smp_valid, smp_ready, reg_wr, reg_rd, irq, rd_d;
	logic signed [SAMPLE_W-1:0]   smp_x, smp_y, smp_z;
	logic [3:0]                   reg_addr;
	logic [7:0]                   reg_wdata, reg_rdata;
	tiltq_note_t                  notes[$];
	tiltq_note_t                  nt;
	int                           fails, checks_done, cycles, fx, fy, fz, axz, ayz, t;
	integer                       seed = 32'hcc72;
	logic [1:0]                   qxz, qyz;
	logic                         fxz, fyz, kxz, kyz, qchg;
	int tab [7][6] = '{'{0, 'h79, 7, 0, 0, 1000}, '{0, 'h79, 7, 1000, -1000, -1000},
		'{0, 'h79, 0, 1000, -1000, 1000}, '{3, 'h69, 7, -1732, 100, 1000},
		'{0, 'h49, 7, 500, 500, -500}, '{0, 'h71, 7, 1000, 0, 0}, '{1, 'h79, 7, 0, 0, 1000}};
	logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h79, 8'h00, 8'h00, 8'h00};

	tiltq_status_top tiltq_status_top_i (.clk(clk), .rst_n(rst_n), .smp_x(smp_x),
		.smp_y(smp_y), .smp_z(smp_z), .smp_valid(smp_valid), .smp_ready(smp_ready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	tiltq_accel_model tiltq_accel_model_i (.clk(clk), .smp_ready(smp_ready), .smp_x(smp_x),
		.smp_y(smp_y), .smp_z(smp_z), .smp_valid(smp_valid));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read checker: oldest note against the data of the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= reg_rd;
		cycles <= cycles + 1;
		if (rd_d === 1'b1) begin
			nt = notes.pop_front();
			if (nt.ang) begin
				`CHK(reg_rdata[7] & nt.care[7], nt.exp[7] & nt.care[7])
				`CHK(near(reg_rdata[6:0], nt.exp[6:0]), 1'b1)
			end else begin
				`CHK(reg_rdata & nt.care, nt.exp & nt.care)
			end
		end
		// Whole run is about 600 cycles
		if (cycles == 8000) begin
			fails++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic near(input logic [6:0] g, input logic [6:0] e);
		return ({1'b0, g} + 8'h01 >= {1'b0, e}) && ({1'b0, g} <= {1'b0, e} + 8'h01);
	endfunction : near

	function automatic int deg(input int a, input int z);
		real ra, rz;
		// No vector at all: the core saturates at 90
		if (a == 0 && z == 0)
			return 90;
		ra = (a < 0) ? -a : a;
		rz = (z < 0) ? -z : z;
		return $rtoi($atan2(ra, rz) * 57.2957795 + 0.5);
	endfunction : deg

	// Zero counts as positive
	function automatic logic [1:0] qc(input int a, input int z);
		if (a >= 0)
			return (z >= 0) ? 2'h0 : 2'h1;
		return (z >= 0) ? 2'h3 : 2'h2;
	endfunction : qc

	// {known, flag}: unknown where rounding slack could tip the comparison
	function automatic logic [1:0] jmp(input int n, input int p, input int th);
		int d;
		d = (n > p) ? n - p : p - n;
		return {(d > th + 2) || (d < th - 2), d > th};
	endfunction : jmp

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] c, input bit g);
		notes.push_back('{e, c, g});
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	// One execution: configure, predict, send a sample, read all status registers back
	task automatic run(input int lp, input logic [7:0] cfg, input logic [7:0] msk,
		input int x, input int y, input int z);
		logic [1:0] jx, jy, nqx, nqy;
		logic [2:0] ev, evc;
		int nx, ny, w;
		wr(OFS_LP_COEF, lp[7:0]);
		rd(OFS_LP_COEF, lp[7:0], 8'hff, 0);
		wr(OFS_TILT_CFG, cfg | 8'h80);
		rd(OFS_TILT_CFG, cfg, 8'hff, 0);
		wr(OFS_IRQ_MASK, msk);
		fx += (x - fx) >>> lp;
		fy += (y - fy) >>> lp;
		fz += (z - fz) >>> lp;
		nx = deg(fx, fz);
		ny = deg(fy, fz);
		jx = jmp(nx, axz, int'(cfg[3:0]));
		jy = jmp(ny, ayz, int'(cfg[3:0]));
		nqx = qc(fx, fz);
		nqy = qc(fy, fz);
		ev = 3'h0;
		evc = 3'h7;
		if (cfg[XZ_EN_BIT] || cfg[YZ_EN_BIT]) begin
			qchg = (cfg[XZ_EN_BIT] && nqx != qxz) || (cfg[YZ_EN_BIT] && nqy != qyz);
			ev[2] = qchg;
		end
		if (cfg[XZ_EN_BIT]) begin
			{axz, qxz, fxz, kxz, ev[0], evc[0]} = {nx, nqx, jx[0], jx[1], jx[0], jx[1]};
		end
		if (cfg[YZ_EN_BIT]) begin
			{ayz, qyz, fyz, kyz, ev[1], evc[1]} = {ny, nqy, jy[0], jy[1], jy[0], jy[1]};
		end
		tiltq_accel_model_i.send(x, y, z, 2);
		@(posedge clk);
		for (w = 0; w < 40 && tiltq_accel_model_i.rdy_s !== 1'b1; w++) @(posedge clk);
		`CHK(tiltq_accel_model_i.rdy_s, 1'b1)
		rd(OFS_XZ_STATUS, {fxz, axz[6:0]}, {kxz, 7'h7f}, 1);
		rd(OFS_YZ_STATUS, {fyz, ayz[6:0]}, {kyz, 7'h7f}, 1);
		rd(OFS_XY_STATUS, 8'h00, 8'hff, 0);
		rd(OFS_QUAD_STATUS, {qchg, 1'b0, qxz, qyz, 2'b00}, 8'hff, 0);
		rd(OFS_IRQ_STATUS, {5'h0, ev}, {5'h1f, evc}, 0);
		if ((ev & evc & msk[2:0]) != 3'h0)
			`CHK(irq, 1'b1)
		else if ((msk[2:0] & ~evc) == 3'h0)
			`CHK(irq, 1'b0)
		wr(OFS_IRQ_STATUS, 8'h07);
		rd(OFS_IRQ_STATUS, 8'h00, 8'hff, 0);
		`CHK(irq, 1'b0)
	endtask : run

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, rd_d} = '0;
		{fails, checks_done, cycles, fx, fy, fz, axz, ayz} = '0;
		{qxz, qyz, fxz, fyz, qchg} = '0;
		{kxz, kyz} = 2'b11;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 9; a++)
			rd(a[3:0], rv[a], 8'hff, 0);
		wr(OFS_XZ_STATUS, 8'hff);
		rd(OFS_XZ_STATUS, 8'h00, 8'hff, 0);
		foreach (tab[i])
			run(tab[i][0], tab[i][1][7:0], tab[i][2][7:0], tab[i][3], tab[i][4], tab[i][5]);
		repeat (6) begin
			t = 1 + ($unsigned($random(seed)) % 10);
			run(0, {4'h7, t[3:0]}, 8'h07, $random(seed) % 3000, $random(seed) % 3000,
				$random(seed) % 3000);
		end
		repeat (3) @(posedge clk);
		finish_test();
	end
endmodule : tilt_angle_quadrant_status_tb

// File: test/tiltq_accel_model.sv
// Accelerometer front end model: offers one sample and holds it until taken.
// Assumes the block takes a sample at a rising edge with smp_ready high.
`timescale 1ns/1ps
module tiltq_accel_model
	import tiltq_pkg::*;
(
	input  wire logic                                 clk,
	input  wire logic                                 smp_ready,
	output logic signed [tiltq_pkg::SAMPLE_W-1:0]     smp_x,
	output logic signed [tiltq_pkg::SAMPLE_W-1:0]     smp_y,
	output logic signed [tiltq_pkg::SAMPLE_W-1:0]     smp_z,
	output logic                                      smp_valid
);
	logic rdy_s;

	initial begin
		smp_x = '0;
		smp_y = '0;
		smp_z = '0;
		smp_valid = 1'b0;
		rdy_s = 1'b0;
	end

	// Ready as seen by the next rising edge
	always @(negedge clk) begin
		rdy_s <= smp_ready;
	end

	task automatic send(input int x, input int y, input int z, input int gap);
		repeat (gap) @(posedge clk);
		smp_x <= x[SAMPLE_W-1:0];
		smp_y <= y[SAMPLE_W-1:0];
		smp_z <= z[SAMPLE_W-1:0];
		smp_valid <= 1'b1;
		do @(posedge clk); while (rdy_s !== 1'b1);
		smp_valid <= 1'b0;
		// Released lines move, so a stale sample cannot be reused by luck
		smp_x <= ~x[SAMPLE_W-1:0];
		smp_y <= ~y[SAMPLE_W-1:0];
		smp_z <= ~z[SAMPLE_W-1:0];
	endtask : send
endmodule : tiltq_accel_model
